// *** include/disc_seq_pkg.sv ***
// constants, field layouts and carrier types of the disc sector sequencer
// assumes one core clock and a 32-bit Avalon-MM register port
package disc_seq_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_COMMAND = 4'h0;
	localparam logic [3:0] OFS_MEM_ADDR = 4'h4;
	localparam logic [3:0] OFS_DISC_ADDR = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	// command and cylinder word
	localparam int CMD_START_BIT = 16;
	localparam int CMD_CLEAR_BIT = 15;
	localparam int CMD_OP_LSB = 9;
	localparam int CYL_W = 9;
	// disc address and sector count word
	localparam int SURF_LSB = 9;
	localparam int SECT_LSB = 4;
	localparam logic [4:0] LAST_SECTOR = 5'h17; // octal 27
	localparam logic [1:0] LAST_SURFACE = 2'h3;
	localparam logic [3:0] COUNT_ALL_ONES = 4'hf;
	// address field layout
	localparam int FLD_CYL_LSB = 8;
	localparam int FLD_SECT_LSB = 3;
	localparam int FLD_SURF_LSB = 1;
	// reset values
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// sector format
	localparam int WORD_W = 16;
	localparam int SECTOR_WORDS = 256;
	localparam int FMT_ZERO_WORDS = 22;
	localparam logic [15:0] FMT_SYNC_WORD = 16'h0009; // octal 000011
	// zeros before the first one of the sync word: its bit 3 is the top one
	localparam int SYNC_LEAD_ZEROS = FMT_ZERO_WORDS * WORD_W + WORD_W - 4;
	localparam int SYNC_TAIL_BITS = 3;
	localparam int BAD_FLAG_LSB = WORD_W - 1 - 14;
	localparam int ADDR_BITS = 17;
	localparam int DATA_SYNC_ZEROS = 16;
	localparam int DATA_SYNC_MIN = 8;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_SEEK = 2'h2,
		OP_RECAL = 2'h3
	} op_type;

	// one data channel word request
	typedef struct packed {
		logic valid;
		logic to_mem;
		logic [15:0] addr;
		logic [15:0] data;
	} dch_req_type;

	typedef struct packed {
		logic [8:0] spare;
		logic bad_sector;
		logic data_late;
		logic crc_err;
		logic addr_err;
		logic error;
		logic busy;
		logic done;
	} status_type;
endpackage : disc_seq_pkg

// *** design/disc_sector_transfer_sequencer.sv ***
// disc sector transfer sequencer: registers, two sector buffers, serial path
// assumes an Avalon-MM master, a data channel that answers each request with
// dch_ack, and a drive that pulses bit_strobe once per bit cell
//
// What this block does
// - start with read or write sets busy, clears done, begins the operation
// - each address field must match commanded cylinder and disc address sector, surface
// - read computes a 16-bit checkword over data and compares the stored one
// - read packs bits into words in two buffers; full one drains meanwhile
// - every word moved over the data channel advances the memory address
// - sector counter increments by one right after each address check that matches without data late
// - next sector only without counter overflow; overflow ends the operation
// - after last sector on surfaces 0-2 go to sector 0 of next surface
// - completion clears busy, sets done and raises the interrupt request
// - write start immediately fetches 256 words into a buffer
// - write shifts buffer words out serially while updating the checkword
// - after the 256 data words the checkword follows directly
// - write check without overflow immediately requests filling the other buffer
// - write buffer not full at end of address check: stop with data late
// - format field: 22 zero words, sync word octal 11, 17 address bits
// - then zero sync, one sync bit, 256 words, checkword, zero fill
// - bad-sector flag set: no transfer, halt at once, request interrupt
// - command field: 00 read, 01 write, 10 seek, 11 recalibrate
// - sectors run 0 to octal 27, then sector 0 of next surface
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module disc_sector_transfer_sequencer
	import disc_seq_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output dch_req_type dch_req,
	input wire logic dch_ack,
	input wire logic [15:0] dch_rdata,
	input wire logic bit_strobe,
	input wire logic read_bit,
	output logic write_bit,
	output logic write_gate,
	output logic busy,
	output logic done,
	output logic irq_request
);
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_HUNT = 8'h02,
		S_SYNC = 8'h04,
		S_ADDR = 8'h08,
		S_DSYNC = 8'h10,
		S_DATA = 8'h20,
		S_CHECK = 8'h40,
		S_DRAIN = 8'h80
	} seq_state_type;

	seq_state_type state;
	status_type stat;
	op_type cmd_op;
	logic [15:0] cmd_word, mem_addr, disc_addr, sr, crc, wword, ch_data;
	logic [15:0] bufmem [0:2*SECTOR_WORDS-1];
	logic [8:0] bcnt;
	logic [11:0] dcnt;
	logic [7:0] cidx;
	logic [1:0] full;
	logic [2:0] tail;
	logic [16:0] fld;
	logic [3:0] bitpos;
	logic resp, op_wr, last, sbank, cbank, ch_valid, fill_pend;
	logic err_addr, err_crc, err_late, err_bad;
	logic acc_wr, start, clear_req, sbit, ovf, ch_last;
	logic tail_end, hdr_end, addr_ok, late, go_data, chk_end, chk_ok, eoc;
	logic set_bad, set_addr, set_crc, set_late, drained, finish;

	// one checkword step over one serial bit
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : WORD_RST);
	endfunction : crc_step

	// address field against commanded cylinder and disc address
	function automatic logic addr_match(input logic [16:0] f, input logic [15:0] cw, input logic [15:0] da);
		addr_match = f[FLD_CYL_LSB +: CYL_W] == cw[CYL_W-1:0] && f[FLD_SECT_LSB +: 5] == da[SECT_LSB +: 5]
			&& f[FLD_SURF_LSB +: 2] == da[SURF_LSB +: 2];
	endfunction : addr_match

	// next consecutive sector, rolling onto the next surface
	function automatic logic [15:0] next_sector(input logic [15:0] da);
		next_sector = da;
		if (da[SECT_LSB +: 5] == LAST_SECTOR) begin
			next_sector[SECT_LSB +: 5] = 5'h00;
			next_sector[SURF_LSB +: 2] = da[SURF_LSB +: 2] + 2'h1;
		end else begin
			next_sector[SECT_LSB +: 5] = da[SECT_LSB +: 5] + 5'h01;
		end
	endfunction : next_sector

	// bus decode: one wait state on every access
	assign waitrequest = (read | write) & ~resp;
	assign acc_wr = write & resp;
	assign cmd_op = op_type'(writedata[CMD_OP_LSB +: 2]);
	assign start = acc_wr && address == OFS_COMMAND && (&byteenable[2:0]) && writedata[CMD_START_BIT]
		&& !busy && !ch_valid && (cmd_op == OP_READ || cmd_op == OP_WRITE);
	assign clear_req = acc_wr && address == OFS_COMMAND && (&byteenable[1:0]) && writedata[CMD_CLEAR_BIT];

	// serial side decode
	assign fld = {sr, read_bit};
	assign tail = {sr[1:0], read_bit};
	assign bitpos = dcnt[3:0];
	assign sbit = op_wr ? wword[~bitpos] : read_bit;
	assign ovf = disc_addr[3:0] == COUNT_ALL_ONES;
	assign tail_end = bit_strobe && state == S_SYNC && bcnt == 9'(SYNC_TAIL_BITS - 1);
	assign hdr_end = bit_strobe && state == S_ADDR && bcnt == 9'(ADDR_BITS - 1);
	assign addr_ok = addr_match(fld, cmd_word, disc_addr);
	assign late = op_wr ? !full[sbank] : full[sbank];
	assign go_data = hdr_end && addr_ok && !late;
	assign chk_end = bit_strobe && state == S_CHECK && bcnt == (op_wr ? 9'(WORD_W) : 9'(WORD_W - 1));
	assign chk_ok = op_wr || {sr[14:0], read_bit} == crc;
	assign eoc = disc_addr[SECT_LSB +: 5] == LAST_SECTOR && disc_addr[SURF_LSB +: 2] == LAST_SURFACE;

	// terminating events
	assign set_bad = tail_end && {tail[2], 1'b0, tail[0]} == FMT_SYNC_WORD[2:0] && tail[BAD_FLAG_LSB];
	assign set_addr = (hdr_end && !addr_ok) || (chk_end && chk_ok && !last && eoc);
	assign set_crc = chk_end && !chk_ok;
	assign set_late = hdr_end && addr_ok && late;
	assign drained = state == S_DRAIN && full == 2'b00 && !ch_valid;
	assign finish = set_bad | set_addr | set_crc | set_late | drained | (chk_end && chk_ok && last && op_wr);

	// status word and outputs
	assign stat = '{spare: 9'h000, bad_sector: err_bad, data_late: err_late, crc_err: err_crc,
		addr_err: err_addr, error: err_bad | err_late | err_crc | err_addr, busy: busy, done: done};
	assign dch_req = '{valid: ch_valid, to_mem: !op_wr, addr: mem_addr, data: ch_data};
	assign irq_request = done;

	// bus answer: read data is caught when the wait state ends
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			resp <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			resp <= (read | write) & ~resp;
			if (read & ~resp) begin
				if (address == OFS_COMMAND) readdata <= {16'h0000, cmd_word};
				else if (address == OFS_MEM_ADDR) readdata <= {16'h0000, mem_addr};
				else if (address == OFS_DISC_ADDR) readdata <= {16'h0000, disc_addr};
				else if (address == OFS_STATUS) readdata <= {16'h0000, stat};
				else readdata <= 32'h0000_0000;
			end
		end
	end

	// command and cylinder word, locked while busy
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) cmd_word <= WORD_RST;
		else if (acc_wr && address == OFS_COMMAND && (&byteenable[1:0]) && !busy) cmd_word <= writedata[15:0];
	end

	// memory address: loaded by software, stepped per channel word
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) mem_addr <= WORD_RST;
		else if (acc_wr && address == OFS_MEM_ADDR && (&byteenable[1:0]) && !busy) mem_addr <= writedata[15:0];
		else if (ch_valid && dch_ack) mem_addr <= mem_addr + 16'h0001;
	end

	// disc address and count: counted after each matching check without data late, advanced per sector
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) disc_addr <= WORD_RST;
		else if (acc_wr && address == OFS_DISC_ADDR && (&byteenable[1:0]) && !busy) disc_addr <= writedata[15:0];
		else if (go_data) disc_addr[3:0] <= disc_addr[3:0] + 4'h1;
		else if (chk_end && chk_ok && !last && !eoc) disc_addr <= next_sector(disc_addr);
	end

	// busy, done and error flags; a set of done or an error flag beats a clear in the same cycle, but finish beats start on busy
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			err_addr <= 1'b0;
			err_crc <= 1'b0;
			err_late <= 1'b0;
			err_bad <= 1'b0;
		end else begin
			if (start || clear_req) begin
				done <= 1'b0;
				err_addr <= 1'b0;
				err_crc <= 1'b0;
				err_late <= 1'b0;
				err_bad <= 1'b0;
			end
			if (start) busy <= 1'b1;
			if (finish) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
			if (set_addr) err_addr <= 1'b1;
			if (set_crc) err_crc <= 1'b1;
			if (set_late) err_late <= 1'b1;
			if (set_bad) err_bad <= 1'b1;
		end
	end

	// serial sequencer: header hunt, address check, data and checkword
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			bcnt <= 9'h000;
			dcnt <= 12'h000;
			sr <= WORD_RST;
			crc <= CRC_INIT;
			wword <= WORD_RST;
			write_bit <= 1'b0;
			write_gate <= 1'b0;
			sbank <= 1'b0;
			last <= 1'b0;
			op_wr <= 1'b0;
		end else if (start) begin
			state <= S_HUNT;
			bcnt <= 9'h000;
			sbank <= 1'b0;
			last <= 1'b0;
			op_wr <= cmd_op == OP_WRITE;
		end else if (finish) begin
			state <= S_IDLE;
			write_gate <= 1'b0;
			write_bit <= 1'b0;
		end else if (bit_strobe) begin
			case (state)
				S_HUNT: begin
					if (read_bit) begin
						state <= (bcnt >= 9'(SYNC_LEAD_ZEROS)) ? S_SYNC : S_HUNT;
						bcnt <= 9'h000;
					end else if (bcnt != 9'h1ff) begin
						bcnt <= bcnt + 9'h001;
					end
				end
				S_SYNC: begin
					sr <= {sr[14:0], read_bit};
					bcnt <= bcnt + 9'h001;
					if (tail_end) begin
						bcnt <= 9'h000;
						state <= ({tail[2], 1'b0, tail[0]} == FMT_SYNC_WORD[2:0]) ? S_ADDR : S_HUNT;
					end
				end
				S_ADDR: begin
					sr <= {sr[14:0], read_bit};
					bcnt <= bcnt + 9'h001;
					if (hdr_end) begin
						state <= S_DSYNC;
						bcnt <= 9'h000;
						last <= ovf;
						write_gate <= op_wr;
						wword <= bufmem[{sbank, 8'h00}];
					end
				end
				S_DSYNC: begin
					crc <= CRC_INIT;
					dcnt <= 12'h000;
					if (op_wr) begin
						write_bit <= bcnt == 9'(DATA_SYNC_ZEROS);
						bcnt <= bcnt + 9'h001;
						if (bcnt == 9'(DATA_SYNC_ZEROS)) state <= S_DATA;
					end else if (!read_bit) begin
						bcnt <= (bcnt == 9'h1ff) ? bcnt : bcnt + 9'h001;
					end else if (bcnt >= 9'(DATA_SYNC_MIN)) begin
						state <= S_DATA;
					end else begin
						bcnt <= 9'h000;
					end
				end
				S_DATA: begin
					crc <= crc_step(crc, sbit);
					sr <= {sr[14:0], read_bit};
					write_bit <= sbit;
					dcnt <= dcnt + 12'h001;
					if (op_wr && bitpos == 4'hf) wword <= bufmem[{sbank, dcnt[11:4] + 8'h01}];
					if (dcnt == 12'hfff) begin
						state <= S_CHECK;
						bcnt <= 9'h000;
					end
				end
				S_CHECK: begin
					sr <= {sr[14:0], read_bit};
					write_bit <= bcnt[4] ? 1'b0 : crc[~bcnt[3:0]];
					bcnt <= bcnt + 9'h001;
					if (chk_end) begin
						write_gate <= 1'b0;
						bcnt <= 9'h000;
						sbank <= !sbank;
						state <= last ? S_DRAIN : S_HUNT;
					end
				end
				default: state <= state;
			endcase
		end
	end

	// sector buffers: read fills from the serial side, write from the channel
	always_ff @(posedge core_clk) begin
		if (ch_valid && dch_ack && op_wr) bufmem[{cbank, cidx}] <= dch_rdata;
		else if (bit_strobe && state == S_DATA && !op_wr && bitpos == 4'hf)
			bufmem[{sbank, dcnt[11:4]}] <= {sr[14:0], read_bit};
	end

	assign ch_last = ch_valid && dch_ack && cidx == 8'hff;

	// buffer full flags shared by channel and serial sides
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			full <= 2'b00;
		end else if (start) begin
			full <= 2'b00;
		end else begin
			if (ch_last && !op_wr) full[cbank] <= 1'b0;
			if (chk_end && op_wr) full[sbank] <= 1'b0;
			if (chk_end && chk_ok && !op_wr) full[sbank] <= 1'b1;
			if (ch_last && op_wr) full[cbank] <= 1'b1;
		end
	end

	// data channel: one word per request, banks taken in turn
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ch_valid <= 1'b0;
			cbank <= 1'b0;
			cidx <= 8'h00;
			fill_pend <= 1'b0;
			ch_data <= WORD_RST;
		end else begin
			if (ch_valid) begin
				if (dch_ack) begin
					cidx <= cidx + 8'h01;
					ch_valid <= 1'b0;
					if (cidx == 8'hff) begin
						cbank <= !cbank;
						fill_pend <= 1'b0;
					end
				end
			end else if (busy && (op_wr ? fill_pend : full[cbank])) begin
				ch_valid <= 1'b1;
				ch_data <= bufmem[{cbank, cidx}];
			end
			if (start) begin
				cbank <= 1'b0;
				cidx <= 8'h00;
				fill_pend <= cmd_op == OP_WRITE;
			end else if (go_data && op_wr && !ovf) begin
				fill_pend <= 1'b1;
			end
		end
	end

	a_start_busy: assert property (@(posedge core_clk) disable iff (!nrst) start |=> busy && !done)
		else $error("start did not set busy and clear done");
	a_finish_done: assert property (@(posedge core_clk) disable iff (!nrst)
		finish |=> !busy && done && irq_request)
		else $error("completion did not clear busy and raise done");
	a_addr_step: assert property (@(posedge core_clk) disable iff (!nrst)
		ch_valid && dch_ack |=> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("memory address did not step by one");
	a_count_step: assert property (@(posedge core_clk) disable iff (!nrst)
		go_data |=> disc_addr[3:0] == $past(disc_addr[3:0]) + 4'h1 && last == $past(ovf))
		else $error("sector counter did not step after address check");
	a_surface_roll: assert property (@(posedge core_clk) disable iff (!nrst)
		chk_end && chk_ok && !last && !eoc && disc_addr[SECT_LSB +: 5] == LAST_SECTOR
		|=> disc_addr[SECT_LSB +: 5] == 5'h00 && disc_addr[SURF_LSB +: 2] == $past(disc_addr[SURF_LSB +: 2]) + 2'h1)
		else $error("no roll to sector 0 of next surface");
	a_late_stop: assert property (@(posedge core_clk) disable iff (!nrst)
		hdr_end && addr_ok && op_wr && !full[sbank] |=> err_late && !busy && state == S_IDLE)
		else $error("unfilled write buffer did not stop with data late");
	a_bad_halt: assert property (@(posedge core_clk) disable iff (!nrst)
		set_bad |=> state == S_IDLE && err_bad && done && !write_gate)
		else $error("bad sector did not halt the operation");
	a_crc_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		set_crc |=> err_crc && stat.error && done)
		else $error("checkword mismatch not flagged");
	a_fill_next: assert property (@(posedge core_clk) disable iff (!nrst)
		go_data && op_wr && !ovf |-> ##[1:3] ch_valid)
		else $error("next buffer fill not requested");
	a_last_ends: assert property (@(posedge core_clk) disable iff (!nrst)
		chk_end && chk_ok && last && op_wr |=> !busy ##1 state == S_IDLE)
		else $error("overflowed count did not end the write");
endmodule : disc_sector_transfer_sequencer
`default_nettype wire

// *** dv/data_channel_model.sv ***
// data channel model: a small memory that answers the sequencer's word requests
// assumes one core clock; delay sets the wait cycles before each acknowledge
`timescale 1ns/1ps
`default_nettype none
module data_channel_model
	import disc_seq_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire dch_req_type dch_req,
	input wire logic [7:0] delay,
	output logic dch_ack,
	output logic [15:0] dch_rdata
);
	logic [15:0] mem [0:1023];
	logic [7:0] wait_cnt;
	// acknowledge a pending word after the programmed wait, store drained words
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dch_ack <= 1'b0;
			wait_cnt <= 8'h00;
		end else begin
			dch_ack <= 1'b0;
			if (dch_req.valid && !dch_ack && wait_cnt >= delay) begin
				dch_ack <= 1'b1;
				wait_cnt <= 8'h00;
			end else if (dch_req.valid && !dch_ack) begin
				wait_cnt <= wait_cnt + 8'h01;
			end
			if (dch_ack && dch_req.valid && dch_req.to_mem) begin
				mem[dch_req.addr[9:0]] <= dch_req.data; // word taken at the ack edge
			end
		end
	end
	// fetch data only valid with acknowledge, inverted otherwise
	assign dch_rdata = dch_ack ? (dch_req.addr ^ 16'ha5c3) : ~(dch_req.addr ^ 16'ha5c3);
endmodule : data_channel_model
`default_nettype wire

// *** dv/disc_sector_transfer_sequencer_tb.sv ***
// testbench of the disc sector sequencer: bus tasks, drive bit stream, scenarios
// assumes the data channel model on the far side and the drive played by the bench
`timescale 1ns/1ps
`default_nettype none
module disc_sector_transfer_sequencer_tb
	import disc_seq_pkg::*;
;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic bit_strobe = 1'b0;
	logic read_bit = 1'b0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [7:0] delay = 8'h00;
	logic [31:0] readdata;
	logic waitrequest, dch_ack, write_bit, write_gate, busy, done, irq_request;
	logic [15:0] dch_rdata;
	dch_req_type dch_req;
	int err_count = 0;
	int n_checks = 0;
	logic wq[$];

	disc_sector_transfer_sequencer DUT (
		.core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.dch_req(dch_req), .dch_ack(dch_ack), .dch_rdata(dch_rdata), .bit_strobe(bit_strobe),
		.read_bit(read_bit), .write_bit(write_bit), .write_gate(write_gate), .busy(busy),
		.done(done), .irq_request(irq_request)
	);
	data_channel_model far (
		.core_clk(core_clk), .nrst(nrst), .dch_req(dch_req), .delay(delay),
		.dch_ack(dch_ack), .dch_rdata(dch_rdata)
	);

	// 25 MHz core clock
	always #20 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	function automatic logic [15:0] crc_nxt(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ (((c[15] ^ b) == 1'b1) ? CRC_POLY : 16'h0000);
	endfunction : crc_nxt

	function automatic logic [15:0] pat(input int i);
		return 16'(i * 16'h1357) ^ 16'h0f0f;
	endfunction : pat

	// one Avalon access, held until waitrequest is sampled low
	// no cycle limit here: only the watchdog ends a stuck access
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus

	task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rdc

	// one bit cell: capture gated write data, then pulse the strobe
	task automatic sb(input logic b);
		@(negedge core_clk);
		if (write_gate === 1'b1) wq.push_back(write_bit);
		@(posedge core_clk);
		read_bit <= b;
		bit_strobe <= 1'b1;
		@(posedge core_clk);
		bit_strobe <= 1'b0;
	endtask : sb

	// format field: zero words, sync word tail with bad flag, address field
	task automatic hdr(input logic [8:0] cyl, input logic [4:0] sec, input logic [1:0] srf, input logic bad);
		logic [20:0] tail;
		tail = {1'b1, 1'b0, bad, 1'b1, cyl, sec, srf, 1'b0};
		repeat (SYNC_LEAD_ZEROS) sb(1'b0);
		for (int i = 20; i >= 0; i--) sb(tail[i]);
	endtask : hdr

	// data field as the drive returns it, checkword optionally corrupted
	task automatic rsec(input int s, input logic bad_crc);
		logic [15:0] c, w;
		c = CRC_INIT;
		repeat (DATA_SYNC_ZEROS) sb(1'b0);
		sb(1'b1);
		for (int i = 0; i < SECTOR_WORDS; i++) begin
			w = pat(s * 256 + i);
			for (int j = 15; j >= 0; j--) begin
				sb(w[j]);
				c = crc_nxt(c, w[j]);
			end
		end
		c = c ^ {15'h0, bad_crc};
		for (int j = 15; j >= 0; j--) sb(c[j]);
		repeat (16) sb(1'b0);
	endtask : rsec

	// capture a written data field and compare words and checkword
	task automatic wchk(input logic [15:0] base);
		int k;
		logic [15:0] c, w, e;
		k = 0;
		c = CRC_INIT;
		wq.delete();
		repeat (4140) sb(1'b0);
		while (k < 40 && wq[k] !== 1'b1) k++;
		chk(32'(k >= 16), 32'h1);
		for (int i = 0; i < 257; i++) begin
			for (int j = 15; j >= 0; j--) begin
				k++;
				w[j] = wq[k];
				if (i < 256) c = crc_nxt(c, wq[k]);
			end
			e = (i < 256) ? ((base + 16'(i)) ^ 16'ha5c3) : c;
			chk(32'(w), 32'(e));
		end
	endtask : wchk

	// idle status, then seek and recalibrate must not start a transfer
	task automatic t_idle;
		logic [31:0] q;
		rdc(OFS_STATUS, 32'h0);
		bus(1'b1, OFS_COMMAND, 32'h1_0000 | (32'(OP_SEEK) << CMD_OP_LSB), q);
		rdc(OFS_STATUS, 32'h0);
		bus(1'b1, OFS_COMMAND, 32'h1_0000 | (32'(OP_RECAL) << CMD_OP_LSB), q);
		rdc(OFS_STATUS, 32'h0);
	endtask : t_idle

	// two-sector write rolling from surface 2 onto surface 3
	task automatic t_write;
		logic [31:0] q;
		bus(1'b1, OFS_MEM_ADDR, 32'h0, q);
		bus(1'b1, OFS_DISC_ADDR, {21'h0, 2'h2, 5'h17, 4'he}, q);
		bus(1'b1, OFS_COMMAND, 32'h1_0005 | (32'(OP_WRITE) << CMD_OP_LSB), q);
		rdc(OFS_STATUS, 32'h2);
		repeat (1000) @(posedge core_clk);
		rdc(OFS_MEM_ADDR, 32'h100);
		hdr(9'h5, 5'h17, 2'h2, 1'b0);
		wchk(16'h0000);
		hdr(9'h5, 5'h0, 2'h3, 1'b0);
		wchk(16'h0100);
		rdc(OFS_STATUS, 32'h1);
		chk(32'(irq_request), 32'h1);
		rdc(OFS_MEM_ADDR, 32'h200);
		bus(1'b0, OFS_DISC_ADDR, 32'h0, q);
		chk(q & 32'hf, 32'h0);
	endtask : t_write

	// two-sector read rolling from surface 1 onto surface 2
	task automatic t_read;
		logic [31:0] q;
		bus(1'b1, OFS_MEM_ADDR, 32'h200, q);
		bus(1'b1, OFS_DISC_ADDR, {21'h0, 2'h1, 5'h17, 4'he}, q);
		bus(1'b1, OFS_COMMAND, 32'h1_0009 | (32'(OP_READ) << CMD_OP_LSB), q);
		hdr(9'h9, 5'h17, 2'h1, 1'b0);
		rsec(0, 1'b0);
		hdr(9'h9, 5'h0, 2'h2, 1'b0);
		rsec(1, 1'b0);
		repeat (1000) @(posedge core_clk);
		rdc(OFS_STATUS, 32'h1);
		rdc(OFS_MEM_ADDR, 32'h400);
		for (int i = 0; i < 512; i++) chk(32'(far.mem[10'h200 + i]), 32'(pat(i)));
	endtask : t_read

	// single-sector operation that must end early with the given flags
	task automatic t_err(input logic [1:0] op, input logic [8:0] cyl, input logic bad, input logic badcrc,
		input logic [7:0] dly, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		delay <= dly;
		bus(1'b1, OFS_MEM_ADDR, 32'h0, q);
		bus(1'b1, OFS_DISC_ADDR, 32'h3f, q);
		bus(1'b1, OFS_COMMAND, 32'h1_0007 | (32'(op) << CMD_OP_LSB), q);
		hdr(cyl, 5'h3, 2'h0, bad);
		if (badcrc) rsec(0, 1'b1);
		repeat (20) sb(1'b0);
		bus(1'b0, OFS_STATUS, 32'h0, q);
		chk(q & mask, exp);
		// clear bit drops done and every error flag
		bus(1'b1, OFS_COMMAND, 32'h8000, q);
		rdc(OFS_STATUS, 32'h0);
		repeat (int'(dly) * 300) @(posedge core_clk);
		delay <= 8'h00;
	endtask : t_err

	// watchdog for a hung handshake
	initial begin
		repeat (90000) @(posedge core_clk);
		err_count++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		t_idle();
		t_write();
		t_read();
		t_err(OP_READ, 9'h6, 1'b0, 1'b0, 8'h00, 32'h7f, 32'h0d);
		t_err(OP_READ, 9'h7, 1'b1, 1'b0, 8'h00, 32'h7f, 32'h45);
		t_err(OP_READ, 9'h7, 1'b0, 1'b1, 8'h00, 32'h7f, 32'h15);
		t_err(OP_WRITE, 9'h7, 1'b0, 1'b0, 8'h14, 32'h7f, 32'h25);
		conclude();
	end
endmodule : disc_sector_transfer_sequencer_tb
`default_nettype wire
